// File: counter_array_pkg.sv
`default_nettype none
package counter_array_pkg;
	// geometry
	localparam int UNITS         = 5;
	localparam int WATCHDOG_UNIT = 4;
	localparam int BYTE_W        = 8;
	localparam int COUNT_W       = 16;
	localparam int MODE_W        = 7;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_CONTROL    = 8'hD8;
	localparam logic [7:0] IDX_ARRAY_MODE = 8'hD9;
	localparam logic [7:0] IDX_MODE_BASE  = 8'hDA;
	localparam logic [7:0] IDX_COUNT_LOW  = 8'hE9;
	localparam logic [7:0] IDX_CMP_LOW    = 8'hEA;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'hF9;
	localparam logic [7:0] IDX_CMP_HIGH   = 8'hFA;
	// module mode bit positions
	localparam int MODE_COMPARE_EN = 6;
	localparam int MODE_RISE       = 5;
	localparam int MODE_FALL       = 4;
	localparam int MODE_MATCH      = 3;
	localparam int MODE_TOGGLE     = 2;
	localparam int MODE_PWM        = 1;
	localparam int MODE_IRQ_EN     = 0;
	// control and array mode bit positions
	localparam int CONTROL_RUN    = 6;
	localparam int ARRAY_WATCHDOG = 6;
	// reset values and limits
	localparam logic [7:0]  BYTE_RESET = 8'h00;
	localparam logic [6:0]  MODE_RESET = 7'h00;
	localparam logic [4:0]  FLAG_RESET = 5'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_MAX   = 8'hFF;
	localparam logic [15:0] COUNT_ONE  = 16'h0001;
	// bus codes
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'h0;
	localparam logic [21:0] HADDR_HIGH_ZERO = 22'h000000;
	typedef enum {BUS_IDLE, BUS_DATA} bus_state_t;
endpackage
`default_nettype wire

// File: module_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// one compare/capture unit as seen from the register file
interface module_link_if;
	logic       wr_low;
	logic       wr_high;
	logic       wr_mode;
	logic [7:0] wdata;
	logic [7:0] cmp_low;
	logic [7:0] cmp_high;
	logic [6:0] mode;
	logic       event_hit;
	logic       watchdog_hit;
	modport top (output wr_low, wr_high, wr_mode, wdata,
		input cmp_low, cmp_high, mode, event_hit, watchdog_hit);
	modport unit (input wr_low, wr_high, wr_mode, wdata,
		output cmp_low, cmp_high, mode, event_hit, watchdog_hit);
endinterface
`default_nettype wire

// File: pin_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_edge_sync #(
	parameter int W = 5
) (
	// clocking
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	// pins and edges
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] last;

	// two flops before use, third one only for edge compare
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta   <= '0;
			stable <= '0;
			last   <= '0;
		end else if (ce) begin
			meta   <= raw;
			stable <= meta; // [RULE21]
			last   <= stable;
		end
	end

	// reset level matches an idle low pin, so no false edge follows reset
	assign rise = stable & ~last; // [RULE21]
	assign fall = ~stable & last; // [RULE21]
endmodule
`default_nettype wire

// File: compare_unit.sv
`timescale 1ns/1ns
`default_nettype none
module compare_unit (
	// clocking
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// shared counter view
	input  wire logic [15:0] counter,
	input  wire logic        count_step,
	input  wire logic        low_wrap,
	input  wire logic        rise,
	input  wire logic        fall,
	input  wire logic        watchdog_allowed,
	// register side
	module_link_if.unit      link,
	// pin side
	output logic             pin_out,
	output logic             pin_oe
);
	logic capture_hit;
	logic compare_hit;
	logic pwm_on;

	// decoded mode conditions
	assign capture_hit = (link.mode[counter_array_pkg::MODE_RISE] && rise) ||
		(link.mode[counter_array_pkg::MODE_FALL] && fall); // [RULE1]
	assign compare_hit = count_step && link.mode[counter_array_pkg::MODE_COMPARE_EN] &&
		link.mode[counter_array_pkg::MODE_MATCH] &&
		counter == {link.cmp_high, link.cmp_low}; // [RULE3] [RULE15]
	assign pwm_on = link.mode[counter_array_pkg::MODE_PWM] &&
		link.mode[counter_array_pkg::MODE_COMPARE_EN]; // [RULE13]
	assign link.event_hit = capture_hit || compare_hit; // [RULE19]
	assign link.watchdog_hit = compare_hit && watchdog_allowed; // [RULE14]

	//////////////////////////////////////////////////////////////////////
	// low byte: software, capture, or pwm reload at low byte wrap
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			link.cmp_low <= counter_array_pkg::BYTE_RESET;
		end else if (ce) begin
			if (link.wr_low) begin
				link.cmp_low <= link.wdata;
			end else if (capture_hit) begin
				link.cmp_low <= counter[7:0]; // [RULE1] [RULE20]
			end else if (pwm_on && low_wrap) begin
				link.cmp_low <= link.cmp_high; // [RULE12]
			end
		end
	end

	// high byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			link.cmp_high <= counter_array_pkg::BYTE_RESET;
		end else if (ce) begin
			if (link.wr_high) begin
				link.cmp_high <= link.wdata;
			end else if (capture_hit) begin
				link.cmp_high <= counter[15:8]; // [RULE1] [RULE20]
			end
		end
	end

	// mode; byte writes steer the compare enable so no stale match fires
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			link.mode <= counter_array_pkg::MODE_RESET;
		end else if (ce) begin
			if (link.wr_mode) begin
				link.mode <= link.wdata[6:0]; // [RULE7]
			end else if (link.wr_low) begin
				link.mode[counter_array_pkg::MODE_COMPARE_EN] <= 1'b0; // [RULE4]
			end else if (link.wr_high) begin
				link.mode[counter_array_pkg::MODE_COMPARE_EN] <= 1'b1; // [RULE5]
			end
		end
	end

	// pin: pwm level or toggle on match
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else if (ce) begin
			pin_oe <= pwm_on || (link.mode[counter_array_pkg::MODE_TOGGLE] &&
				link.mode[counter_array_pkg::MODE_MATCH] &&
				link.mode[counter_array_pkg::MODE_COMPARE_EN]);
			if (pwm_on) begin
				pin_out <= counter[7:0] >= link.cmp_low; // [RULE11] [RULE10]
			end else if (compare_hit && link.mode[counter_array_pkg::MODE_TOGGLE]) begin
				pin_out <= ~pin_out; // [RULE8]
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_capture_copy: assert property (ce && capture_hit && !link.wr_low && !link.wr_high
		|=> {link.cmp_high, link.cmp_low} == $past(counter)) // [RULE1]
		else $error("capture did not copy the counter");
	a_low_write_clear: assert property (ce && link.wr_low && !link.wr_mode
		|=> !link.mode[counter_array_pkg::MODE_COMPARE_EN]) // [RULE4]
		else $error("low byte write left compare enabled");
	a_high_write_set: assert property (ce && link.wr_high && !link.wr_mode
		|=> link.mode[counter_array_pkg::MODE_COMPARE_EN]) // [RULE5]
		else $error("high byte write did not enable compare");
	a_toggle_on_match: assert property (ce && compare_hit && !pwm_on &&
		link.mode[counter_array_pkg::MODE_TOGGLE] |=> pin_out != $past(pin_out)) // [RULE8]
		else $error("pin did not toggle on match");
	a_pwm_level: assert property (ce && pwm_on
		|=> pin_out == ($past(counter[7:0]) >= $past(link.cmp_low))) // [RULE11]
		else $error("pwm level wrong");
	a_pwm_reload: assert property (ce && pwm_on && low_wrap && !link.wr_low && !capture_hit
		|=> link.cmp_low == $past(link.cmp_high)) // [RULE12]
		else $error("pwm duty not reloaded at wrap");
	a_mode_write: assert property (ce && link.wr_mode
		|=> link.mode == $past(link.wdata[6:0])) // [RULE7]
		else $error("mode write lost");
	c_pwm_run: cover property (ce && pwm_on && low_wrap);
	c_toggle: cover property (ce && compare_hit && link.mode[counter_array_pkg::MODE_TOGGLE]);
endmodule
`default_nettype wire

// File: counter_array_compare_capture.sv
// What this block does
// RULE1: a set edge enable makes a pin edge copy the counter into the unit's pair.
// RULE2: interrupt request only when a unit's event flag and its interrupt enable are set.
// RULE3: compare enable plus match compares counter with the pair and flags equality.
// RULE4: a low byte write clears compare enable when it is set.
// RULE5: a high byte write sets compare enable.
// RULE6: software should load both bytes, low then high, before enabling compare.
// RULE7: compare enable stays readable and writable through the mode register.
// RULE8: toggle, match and compare enable together invert the pin on every match; the code skips the toggle while pwm is also enabled.
// RULE9: software writes both compare bytes before enabling fast toggle output.
// RULE10: every unit can run pwm, one shared frequency, separate duty per unit.
// RULE11: pwm pin low while counter low byte is below compare low, else high.
// RULE12: on counter low byte wrap the pwm low byte reloads from the high byte.
// RULE13: pwm acts only with both pwm and compare enable set.
// RULE14: only unit four has the watchdog; otherwise it works as any other unit.
// RULE15: watchdog compares a preloaded sixteen bit value with the counter.
// RULE16: a watchdog match raises an internal reset, not the external reset pin.
// RULE17: software avoids watchdog reset by moving the compare value before a match.
// RULE18: counter low byte is an eight bit register resetting to zero.
// RULE19: a match with match enabled sets the unit's event flag.
// RULE20: each unit's high and low bytes hold one sixteen bit count.
// RULE21: capture pins are synchronised and edge detected before capture.
`timescale 1ns/1ns
`default_nettype none
module counter_array_compare_capture (
	// clock, reset, enable
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// register bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// module pins
	input  wire logic [4:0]  module_pin_in,
	output logic      [4:0]  module_pin_out,
	output logic      [4:0]  module_pin_oe,
	// system
	output logic             irq,
	output logic             watchdog_reset
);
	localparam int N = counter_array_pkg::UNITS;

	counter_array_pkg::bus_state_t state;
	logic [7:0]  addr_idx;
	logic        addr_ok;
	logic        wr_q;
	logic        accept;
	logic        wr_en;
	logic [7:0]  wbyte;
	logic [7:0]  next_rdata;

	logic [15:0] counter;
	logic        run;
	logic [4:0]  flags;
	logic [7:0]  array_mode;
	logic        count_step;
	logic        low_wrap;
	logic        tick;
	logic        wr_count_low;
	logic        wr_count_high;

	logic [N-1:0] rise;
	logic [N-1:0] fall;
	logic [N-1:0] event_hits;
	logic [N-1:0] wd_hits;
	logic [N-1:0] irq_en;
	logic [7:0]   cmp_low_all  [N];
	logic [7:0]   cmp_high_all [N];
	logic [6:0]   mode_all     [N];

	//////////////////////////////////////////////////////////////////////
	// bus slave: one wait state per transfer so reads see committed writes

	assign accept = hsel && hready && htrans == counter_array_pkg::HTRANS_NONSEQ;
	assign wr_en  = ce && state == counter_array_pkg::BUS_DATA && wr_q && addr_ok;
	assign wbyte  = hwdata[7:0];

	// address phase capture and handshake
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= counter_array_pkg::BUS_IDLE;
			addr_idx  <= counter_array_pkg::BYTE_RESET;
			addr_ok   <= 1'b0;
			wr_q      <= 1'b0;
			hreadyout <= 1'b1;
		end else if (ce) begin
			case (state)
				counter_array_pkg::BUS_IDLE: begin
					if (accept) begin
						state     <= counter_array_pkg::BUS_DATA;
						addr_idx  <= haddr[9:2];
						addr_ok   <= haddr[31:10] == counter_array_pkg::HADDR_HIGH_ZERO;
						wr_q      <= hwrite;
						hreadyout <= 1'b0;
					end
				end
				counter_array_pkg::BUS_DATA: begin
					state     <= counter_array_pkg::BUS_IDLE;
					hreadyout <= 1'b1;
				end
				default: begin
					state     <= counter_array_pkg::BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// response is always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= counter_array_pkg::HRESP_OKAY;
		end else begin
			hresp <= counter_array_pkg::HRESP_OKAY;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = counter_array_pkg::BYTE_RESET;
		if (!addr_ok) begin
			next_rdata = counter_array_pkg::BYTE_RESET;
		end else if (addr_idx == counter_array_pkg::IDX_CONTROL) begin
			next_rdata = {1'b0, run, 1'b0, flags};
		end else if (addr_idx == counter_array_pkg::IDX_ARRAY_MODE) begin
			next_rdata = array_mode;
		end else if (addr_idx == counter_array_pkg::IDX_COUNT_LOW) begin
			next_rdata = counter[7:0]; // [RULE18]
		end else if (addr_idx == counter_array_pkg::IDX_COUNT_HIGH) begin
			next_rdata = counter[15:8];
		end else begin
			for (int i = 0; i < N; i++) begin
				if (addr_idx == counter_array_pkg::IDX_MODE_BASE + 8'(i)) begin
					next_rdata = {1'b0, mode_all[i]}; // [RULE7]
				end else if (addr_idx == counter_array_pkg::IDX_CMP_LOW + 8'(i)) begin
					next_rdata = cmp_low_all[i];
				end else if (addr_idx == counter_array_pkg::IDX_CMP_HIGH + 8'(i)) begin
					next_rdata = cmp_high_all[i];
				end
			end
		end
	end

	// read data stands from the end of the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ce && state == counter_array_pkg::BUS_DATA && !wr_q) begin
			hrdata <= {24'h000000, next_rdata};
		end
	end

	//////////////////////////////////////////////////////////////////////
	// shared counter

	assign wr_count_low  = wr_en && addr_idx == counter_array_pkg::IDX_COUNT_LOW;
	assign wr_count_high = wr_en && addr_idx == counter_array_pkg::IDX_COUNT_HIGH;
	// a software load wins over counting for that cycle
	assign tick = run && !wr_count_low && !wr_count_high;

	// one time base for every unit, so all pwm outputs share a frequency
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter <= counter_array_pkg::COUNT_RESET; // [RULE18]
		end else if (ce) begin
			if (wr_count_low) begin
				counter[7:0] <= wbyte; // [RULE18]
			end else if (wr_count_high) begin
				counter[15:8] <= wbyte;
			end else if (tick) begin
				counter <= counter + counter_array_pkg::COUNT_ONE; // [RULE10]
			end
		end
	end

	// compare only once per new counter value, so a halted counter
	// cannot keep firing the same match
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_step <= 1'b0;
			low_wrap   <= 1'b0;
		end else if (ce) begin
			count_step <= tick || wr_count_low || wr_count_high;
			low_wrap   <= tick && counter[7:0] == counter_array_pkg::BYTE_MAX; // [RULE12]
		end
	end

	//////////////////////////////////////////////////////////////////////
	// control and array mode registers

	// flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run   <= 1'b0;
			flags <= counter_array_pkg::FLAG_RESET;
		end else if (ce) begin
			if (wr_en && addr_idx == counter_array_pkg::IDX_CONTROL) begin
				run   <= wbyte[counter_array_pkg::CONTROL_RUN];
				flags <= wbyte[4:0] | event_hits; // [RULE19]
			end else begin
				flags <= flags | event_hits; // [RULE19]
			end
		end
	end

	// array mode holds the watchdog enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			array_mode <= counter_array_pkg::BYTE_RESET;
		end else if (ce && wr_en && addr_idx == counter_array_pkg::IDX_ARRAY_MODE) begin
			array_mode <= wbyte;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// pin synchroniser and units

	pin_edge_sync #(
		.W(N)
	) u_sync (
		.clk  (hclk),
		.rstn (hresetn),
		.ce   (ce),
		.raw  (module_pin_in),
		.rise (rise),
		.fall (fall)
	);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : unit
			module_link_if link ();

			assign link.wdata   = wbyte;
			assign link.wr_low  = wr_en && addr_idx == counter_array_pkg::IDX_CMP_LOW + 8'(g);
			assign link.wr_high = wr_en && addr_idx == counter_array_pkg::IDX_CMP_HIGH + 8'(g);
			assign link.wr_mode = wr_en && addr_idx == counter_array_pkg::IDX_MODE_BASE + 8'(g);
			assign cmp_low_all[g]  = link.cmp_low;
			assign cmp_high_all[g] = link.cmp_high;
			assign mode_all[g]     = link.mode;
			assign event_hits[g]   = link.event_hit;
			assign wd_hits[g]      = link.watchdog_hit;
			assign irq_en[g]       = link.mode[counter_array_pkg::MODE_IRQ_EN];

			compare_unit u_unit (
				.clk              (hclk),
				.rstn             (hresetn),
				.ce               (ce),
				.counter          (counter),
				.count_step       (count_step),
				.low_wrap         (low_wrap),
				.rise             (rise[g]),
				.fall             (fall[g]),
				.watchdog_allowed (g == counter_array_pkg::WATCHDOG_UNIT &&
					array_mode[counter_array_pkg::ARRAY_WATCHDOG]), // [RULE14]
				.link             (link),
				.pin_out          (module_pin_out[g]),
				.pin_oe           (module_pin_oe[g])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// interrupt request and internal watchdog reset

	// request needs both the flag and that unit's enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(flags & irq_en); // [RULE2] [RULE3]
		end
	end

	// a one cycle pulse to the system reset logic; never drives the reset pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_reset <= 1'b0;
		end else if (ce) begin
			watchdog_reset <= |wd_hits; // [RULE16]
		end
	end

	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_counter_advance: assert property (ce && tick
		|=> counter == $past(counter) + counter_array_pkg::COUNT_ONE) // [RULE18]
		else $error("counter did not advance");
	a_flag_on_event: assert property (ce && event_hits[0] |=> flags[0]) // [RULE19]
		else $error("event did not set flag");
	a_irq_gate: assert property (ce && (flags & irq_en) != 5'h00 |=> irq) // [RULE2]
		else $error("flag with enable gave no request");
	a_irq_quiet: assert property (ce && (flags & irq_en) == 5'h00 |=> !irq) // [RULE2]
		else $error("request without enabled flag");
	a_watchdog_fire: assert property (ce && wd_hits[counter_array_pkg::WATCHDOG_UNIT]
		|=> watchdog_reset) // [RULE16]
		else $error("watchdog match gave no reset");
	a_bus_wait: assert property (ce && state == counter_array_pkg::BUS_IDLE && accept
		|=> !hreadyout ##1 hreadyout)
		else $error("wait state not one cycle");
	c_write_read: cover property (wr_en ##[1:4] hreadyout && !wr_q);
	c_watchdog: cover property (watchdog_reset);
endmodule
`default_nettype wire

// File: pin_edge_sync_fix_note.sv
`default_nettype none
`default_nettype wire

// File: pin_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
	// clock
	input  wire logic       hclk,
	// device pins
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	output logic      [4:0] pin_in
);
	logic [4:0] level = 5'h00;
	logic [4:0] last = 5'h00;
	int         toggles [5];
	////////////////////////////////////////
	// capture inputs are always driven from outside, so there is no floating level
	assign pin_in = level;
	// changes are counted only while the device owns the pin, pwm and toggle alike
	always @(posedge hclk) begin
		for (int i = 0; i < 5; i++) begin
			if (pin_oe[i] === 1'b1 && pin_out[i] !== last[i])
				toggles[i]++;
		end
		last <= pin_out;
	end
	// called just after a clock edge, so edges land like any other bench input
	task automatic set_pin(input int n, input logic v);
		level[n] <= v;
	endtask
endmodule
`default_nettype wire

// File: counter_array_compare_capture_tb.sv
`timescale 1ns/1ns
`default_nettype none
module counter_array_compare_capture_tb;
	logic        hclk;
	logic        hresetn;
	logic        ce;
	logic [7:0]  ref_step;
	logic [7:0]  before_freeze;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [4:0]  pin_in;
	logic [4:0]  pin_out;
	logic [4:0]  pin_oe;
	logic        irq;
	logic        watchdog_reset;
	logic [7:0]  rd;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          wd_seen = 0;
	// ce is dropped once in mid-run to prove that it freezes the counter
	counter_array_compare_capture u_counter_array_compare_capture (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.module_pin_in(pin_in), .module_pin_out(pin_out), .module_pin_oe(pin_oe),
		.irq(irq), .watchdog_reset(watchdog_reset)
	);
	pin_partner u_pin_partner (
		.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
	);
	////////////////////////////////////////
	// free-running clock, 8 ns period
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// the reset request is a one-cycle pulse, so it is counted rather than polled
	always @(posedge hclk) begin
		if (watchdog_reset === 1'b1)
			wd_seen++;
	end
	////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// single word transfer; waits on hready only, never on a fixed latency
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= counter_array_pkg::HTRANS_NONSEQ;
		haddr <= {22'h000000, idx, 2'h0};
		hwrite <= w;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
		rd = hrdata[7:0];
		if (k >= 20) begin
			n_fail++;
			finish_test;
		end
		chk({7'h00, hresp}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(rd, e);
	endtask
	// bounded wait: 0 irq, 1 reset pulse, 2 toggle on unit 3
	task automatic wait_hi(input int sel);
		int k;
		for (k = 0; k < 500; k++) begin
			@(posedge hclk);
			if (sel == 0 && irq === 1'b1)
				break;
			if (sel == 1 && wd_seen != 0)
				break;
			if (sel == 2 && u_pin_partner.toggles[3] != 0)
				break;
		end
		if (k == 500) begin
			n_fail++;
			finish_test;
		end
	endtask
	// one low-byte period holds exactly one pwm cycle, whatever the phase
	task automatic duty(input logic [7:0] e0, input logic [7:0] e1);
		logic [7:0] h0;
		logic [7:0] h1;
		h0 = 8'h00;
		h1 = 8'h00;
		repeat (256) begin
			@(posedge hclk);
			h0 = h0 + {7'h00, pin_out[0]};
			h1 = h1 + {7'h00, pin_out[1]};
		end
		chk(h0, e0);
		chk(h1, e1);
	endtask
	////////////////////////////////////////
	initial begin
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, plain storage, unmapped place
		rdc(8'hE9, 8'h00);
		rdc(8'hD8, 8'h00);
		wr(8'hE9, 8'hA5);
		rdc(8'hE9, 8'hA5);
		wr(8'h10, 8'h77);
		rdc(8'h10, 8'h00);
		// compare enable side effects of byte writes on unit 1
		wr(8'hFB, 8'h12);
		rdc(8'hDB, 8'h40);
		wr(8'hEB, 8'h34);
		rdc(8'hDB, 8'h00);
		wr(8'hDB, 8'h48);
		rdc(8'hDB, 8'h48);
		wr(8'hDB, 8'h00);
		// software timer on unit 0, then mask its interrupt
		wr(8'hEA, 8'h10);
		wr(8'hFA, 8'h01);
		wr(8'hDA, 8'h49);
		wr(8'hE9, 8'h0F);
		wr(8'hF9, 8'h01);
		wr(8'hD8, 8'h40);
		wait_hi(0);
		rdc(8'hD8, 8'h41);
		wr(8'hDA, 8'h48);
		repeat (2) @(posedge hclk);
		chk({7'h00, irq}, 8'h00);
		wr(8'hD8, 8'h00);
		wr(8'hDA, 8'h00);
		// capture on unit 2: rising only, then falling only
		wr(8'hDC, 8'h20);
		wr(8'hE9, 8'h34);
		wr(8'hF9, 8'h12);
		u_pin_partner.set_pin(2, 1'b1);
		repeat (6) @(posedge hclk);
		rdc(8'hEC, 8'h34);
		rdc(8'hFC, 8'h12);
		rdc(8'hD8, 8'h04);
		chk({7'h00, irq}, 8'h00);
		wr(8'hDC, 8'h10);
		wr(8'hE9, 8'h99);
		u_pin_partner.set_pin(2, 1'b0);
		repeat (6) @(posedge hclk);
		rdc(8'hEC, 8'h99);
		wr(8'hE9, 8'h55);
		u_pin_partner.set_pin(2, 1'b1);
		repeat (6) @(posedge hclk);
		rdc(8'hEC, 8'h99);
		wr(8'hDC, 8'h00);
		// clock enable low must hold the running counter still
		wr(8'hD8, 8'h40);
		bus(1'b0, 8'hE9, 8'h00);
		ref_step = rd;
		bus(1'b0, 8'hE9, 8'h00);
		ref_step = rd - ref_step;
		bus(1'b0, 8'hE9, 8'h00);
		before_freeze = rd;
		ce <= 1'b0;
		repeat (40) @(posedge hclk);
		ce <= 1'b1;
		bus(1'b0, 8'hE9, 8'h00);
		chk(rd - before_freeze, ref_step);
		wr(8'hD8, 8'h00);
		// high speed output on unit 3
		wr(8'hED, 8'h05);
		wr(8'hFD, 8'h00);
		wr(8'hDD, 8'h4C);
		wr(8'hE9, 8'h00);
		wr(8'hF9, 8'h00);
		wr(8'hD8, 8'h40);
		wait_hi(2);
		chk({7'h00, pin_out[3] & pin_oe[3]}, 8'h01);
		wr(8'hD8, 8'h00);
		wr(8'hDD, 8'h00);
		// pwm on units 0 and 1, unit 2 lacks compare enable
		wr(8'hEA, 8'h40);
		wr(8'hFA, 8'h40);
		wr(8'hEB, 8'hC0);
		wr(8'hFB, 8'hC0);
		wr(8'hDA, 8'h42);
		wr(8'hDB, 8'h42);
		wr(8'hDC, 8'h02);
		wr(8'hD8, 8'h40);
		repeat (300) @(posedge hclk);
		duty(8'hC0, 8'h40);
		chk({7'h00, pin_oe[2]}, 8'h00);
		wr(8'hFA, 8'h80);
		repeat (600) @(posedge hclk);
		duty(8'h80, 8'h40);
		wr(8'hD8, 8'h00);
		wr(8'hDA, 8'h00);
		wr(8'hDB, 8'h00);
		wr(8'hDC, 8'h00);
		// unit 4 as plain timer first, then as watchdog
		wr(8'hEE, 8'h20);
		wr(8'hFE, 8'h01);
		wr(8'hDE, 8'h48);
		wr(8'hE9, 8'h00);
		wr(8'hF9, 8'h01);
		wr(8'hD8, 8'h40);
		repeat (60) @(posedge hclk);
		rdc(8'hD8, 8'h50);
		chk({7'h00, wd_seen != 0}, 8'h00);
		wr(8'hD8, 8'h00);
		wr(8'hD9, 8'h40);
		wr(8'hE9, 8'h00);
		wr(8'hD8, 8'h40);
		wr(8'hEE, 8'h80);
		wr(8'hFE, 8'h01);
		repeat (40) @(posedge hclk);
		chk({7'h00, wd_seen != 0}, 8'h00);
		wait_hi(1);
		finish_test;
	end
endmodule
`default_nettype wire
